// >>> hdl/hbdt_ctrl.sv
// bridge protection and dead-time sequencer
//
// Operation
// - dead time off on leg change
// - stay off until undervoltage clears at start
// - undervoltage while running forces all off
// - overvoltage turns all switches off at once
// - resume below overvoltage recovery, no other fault
// - overcurrent valid only after 10us continuous
// - valid overcurrent holds all off for 5ms
// - resume after 5ms if overcurrent gone
// - still overcurrent: another 5ms off period
// - thermal flag forces all switches off; mode and o_active kept
// - stay off until thermal hysteresis clears
// - hold forward or backward mode 125us before standby; brake drops at once
// - brake: both lower on, both upper off
// - pwm drives lower switch, upper held on
`timescale 1ns/10ps
module hbdt_ctrl (
    input  wire logic       i_ref_clk,        // 40 MHz reference clock
    input  wire logic       i_arst_n,         // async reset, active low
    input  wire logic       i_forward_input,  // direction/pwm input a (pin)
    input  wire logic       i_backward_input, // direction/pwm input b (pin)
    input  wire logic       i_uv_ok,          // supply above start threshold (comparator w/ hysteresis)
    input  wire logic       i_ov_flag,        // supply above overvoltage (comparator w/ hysteresis)
    input  wire logic [3:0] i_current_limit_trip, // per-switch overcurrent comparators
    input  wire logic       i_thermal_flag,   // junction hot (comparator w/ hysteresis)
    output logic            o_upper_switch_a, // gate drive
    output logic            o_lower_switch_a, // gate drive
    output logic            o_upper_switch_b, // gate drive
    output logic            o_lower_switch_b, // gate drive
    output logic            o_active,         // internal circuits powered
    output logic            o_fault           // any protection holding bridge off
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync_reg;                 // reset release chain
    logic       rst_n;                        // synchronised reset

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: three stages, accept when stages two and three agree
    localparam int unsigned NIN = 9;
    logic [NIN-1:0] raw;                      // raw pin inputs
    logic [NIN-1:0] s1_reg;                   // first stage, read by s2 only
    logic [NIN-1:0] s2_reg;                   // second stage
    logic [NIN-1:0] s3_reg;                   // third stage
    logic [NIN-1:0] flt_reg;                  // agreed value

    assign raw = {i_forward_input, i_backward_input, i_uv_ok, i_ov_flag, i_thermal_flag, i_current_limit_trip};

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            flt_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int k = 0; k < NIN; k++) begin
                if (s2_reg[k] == s3_reg[k]) begin
                    flt_reg[k] <= s3_reg[k];   // change counts once both agree
                end
            end
        end
    end

    logic       fwd_in;                       // synced forward
    logic       bwd_in;                       // synced backward
    logic       uv_ok;                        // synced supply ok
    logic       ov;                           // synced overvoltage
    logic       hot;                          // synced thermal
    logic [3:0] trip;                         // synced per-switch trip
    assign {fwd_in, bwd_in, uv_ok, ov, hot, trip} = flt_reg;

    ////////////////////////////////////////////////////////////////////////
    // overcurrent filter and retry timer
    localparam int unsigned CNT_W_L = hbdt_pkg::CNT_W;
    localparam logic [CNT_W_L-1:0] FILT_MAX = CNT_W_L'(hbdt_pkg::OC_FILT_CYC);
    localparam logic [CNT_W_L-1:0] OFF_MAX  = CNT_W_L'(hbdt_pkg::OC_OFF_CYC);
    logic [CNT_W_L-1:0] oc_filt_reg;          // continuous trip count
    logic [CNT_W_L-1:0] oc_off_reg;           // off interval count
    logic               oc_valid;             // filtered overcurrent
    logic               oc_lock;              // off interval running

    // trip must stay high for more than the filter time
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_filt_reg <= '0;
        end else if (!(|trip)) begin
            oc_filt_reg <= '0;                 // any gap restarts the filter
        end else if (oc_filt_reg <= FILT_MAX) begin
            oc_filt_reg <= oc_filt_reg + 1'b1;
        end
    end
    assign oc_valid = (oc_filt_reg > FILT_MAX);

    // off interval; re-arms while the trip is still present at expiry
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_off_reg <= '0;
        end else if (oc_off_reg != '0) begin
            if (oc_off_reg == OFF_MAX && (|trip)) begin
                oc_off_reg <= CNT_W_L'(1);
            end else if (oc_off_reg == OFF_MAX) begin
                oc_off_reg <= '0;
            end else begin
                oc_off_reg <= oc_off_reg + 1'b1;
            end
        end else if (oc_valid) begin
            oc_off_reg <= CNT_W_L'(1);
        end
    end
    assign oc_lock = (oc_off_reg != '0);

    ////////////////////////////////////////////////////////////////////////
    // fault combination; each source clears on its own
    logic fault;                              // bridge forced off
    assign fault = !uv_ok || ov || hot || oc_lock;

    ////////////////////////////////////////////////////////////////////////
    // mode decode with standby hold-over
    localparam int unsigned CNT_W_H = hbdt_pkg::CNT_W;
    localparam logic [CNT_W_H-1:0] HOLD_MAX = CNT_W_H'(hbdt_pkg::HOLD_CYC);
    hbdt_pkg::hbdt_mode_t req_mode;           // mode from inputs
    hbdt_pkg::hbdt_mode_t mode_reg;           // mode in force
    logic [CNT_W_H-1:0]   hold_reg;           // standby hold count
    logic                 pwm_lo;             // pwm phase low in run mode
    logic                 started_reg;        // supply at start level, uv_ok registered each cycle

    // pwm low on the pwm input reads as standby; hold-over keeps mode
    always_comb begin
        unique case ({fwd_in, bwd_in})
            2'b10:   req_mode = hbdt_pkg::HBDT_FWD;
            2'b01:   req_mode = hbdt_pkg::HBDT_BWD;
            2'b11:   req_mode = hbdt_pkg::HBDT_BRAKE;
            2'b00:   req_mode = hbdt_pkg::HBDT_STANDBY;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= hbdt_pkg::HBDT_STANDBY;
            hold_reg <= '0;
        end else if (req_mode != hbdt_pkg::HBDT_STANDBY) begin
            mode_reg <= req_mode;
            hold_reg <= '0;
        end else if (mode_reg == hbdt_pkg::HBDT_BRAKE) begin
            mode_reg <= hbdt_pkg::HBDT_STANDBY; // brake drops at once
        end else if (mode_reg != hbdt_pkg::HBDT_STANDBY) begin
            if (hold_reg >= HOLD_MAX - 1'b1) begin
                mode_reg <= hbdt_pkg::HBDT_STANDBY;
                hold_reg <= '0;
            end else begin
                hold_reg <= hold_reg + 1'b1;
            end
        end
    end
    assign pwm_lo = (req_mode == hbdt_pkg::HBDT_STANDBY);

    // power-up: nothing runs until the supply first reaches start level
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= uv_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wanted switch pattern
    logic [3:0] want;                         // target switches
    always_comb begin
        want = hbdt_pkg::SW_OFF;
        unique case (mode_reg)
            hbdt_pkg::HBDT_FWD: begin
                want[hbdt_pkg::SW_UA] = 1'b1;
                want[hbdt_pkg::SW_LB] = !pwm_lo;
            end
            hbdt_pkg::HBDT_BWD: begin
                want[hbdt_pkg::SW_UB] = 1'b1;
                want[hbdt_pkg::SW_LA] = !pwm_lo;
            end
            hbdt_pkg::HBDT_BRAKE: begin
                want[hbdt_pkg::SW_LA] = 1'b1;
                want[hbdt_pkg::SW_LB] = 1'b1;
            end
            hbdt_pkg::HBDT_STANDBY: begin
                want = hbdt_pkg::SW_OFF;
            end
        endcase
        if (fault || !started_reg) begin
            want = hbdt_pkg::SW_OFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dead-time gate: turn-offs act at once, turn-ons wait dead time
    localparam logic [7:0] DEAD_MAX = 8'(hbdt_pkg::DEAD_CYC);
    logic [3:0] sw_reg;                       // driven switches
    logic [7:0] dead_reg;                     // dead time count
    logic       rising;                       // some switch must turn on

    assign rising = |(want & ~sw_reg);

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_reg   <= hbdt_pkg::SW_OFF;
            dead_reg <= '0;
        end else if (!rising) begin
            sw_reg   <= want;                  // turn-off immediate
            dead_reg <= '0;
        end else if (dead_reg >= DEAD_MAX) begin
            sw_reg   <= want;
            dead_reg <= '0;
        end else begin
            sw_reg   <= sw_reg & want;         // changing legs off
            dead_reg <= dead_reg + 1'b1;
        end
    end

    assign o_upper_switch_a = sw_reg[hbdt_pkg::SW_UA];
    assign o_lower_switch_a = sw_reg[hbdt_pkg::SW_LA];
    assign o_upper_switch_b = sw_reg[hbdt_pkg::SW_UB];
    assign o_lower_switch_b = sw_reg[hbdt_pkg::SW_LB];

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_active <= 1'b0;
            o_fault  <= 1'b0;
        end else begin
            o_active <= started_reg && (mode_reg != hbdt_pkg::HBDT_STANDBY);
            o_fault  <= fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_no_shoot;
        @(posedge i_ref_clk) disable iff (!rst_n)
        !(sw_reg[3] && sw_reg[2]) && !(sw_reg[1] && sw_reg[0]);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("leg shoot-through");

    property p_dead;
        @(posedge i_ref_clk) disable iff (!rst_n)
        |(sw_reg & ~$past(sw_reg)) |-> $past(dead_reg) == DEAD_MAX;
    endproperty
    a_dead: assert property (p_dead) else $error("dead time skipped");

    property p_start;
        @(posedge i_ref_clk) disable iff (!rst_n)
        !started_reg |=> sw_reg == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("drive before start");

    property p_uv;
        @(posedge i_ref_clk) disable iff (!rst_n)
        !uv_ok |-> ##1 sw_reg == 4'h0;
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage drive");

    property p_ov;
        @(posedge i_ref_clk) disable iff (!rst_n)
        ov |=> sw_reg == 4'h0;
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage drive");

    property p_hot;
        @(posedge i_ref_clk) disable iff (!rst_n)
        hot |=> sw_reg == 4'h0;
    endproperty
    a_hot: assert property (p_hot) else $error("thermal drive");

    property p_oc_start;
        @(posedge i_ref_clk) disable iff (!rst_n)
        oc_valid && !oc_lock |=> oc_off_reg == 1;
    endproperty
    a_oc_start: assert property (p_oc_start) else $error("no off interval");

    property p_oc_retry;
        @(posedge i_ref_clk) disable iff (!rst_n)
        oc_off_reg == OFF_MAX && (|trip) |=> oc_lock;
    endproperty
    a_oc_retry: assert property (p_oc_retry) else $error("no retry");

    property p_oc_end;
        @(posedge i_ref_clk) disable iff (!rst_n)
        oc_off_reg == OFF_MAX && !(|trip) |=> !oc_lock;
    endproperty
    a_oc_end: assert property (p_oc_end) else $error("no resume");

    property p_filter;
        @(posedge i_ref_clk) disable iff (!rst_n)
        $rose(|trip) |-> !oc_valid [*8];
    endproperty
    a_filter: assert property (p_filter) else $error("unfiltered trip");

    property p_brake;
        @(posedge i_ref_clk) disable iff (!rst_n)
        mode_reg == hbdt_pkg::HBDT_BRAKE && !fault && started_reg |->
            ##[0:130] sw_reg == 4'h5 || fault || !started_reg || !(mode_reg == hbdt_pkg::HBDT_BRAKE);
    endproperty
    a_brake: assert property (p_brake) else $error("brake pattern");

    c_fwd:   cover property (@(posedge i_ref_clk) sw_reg == 4'h9);
    c_bwd:   cover property (@(posedge i_ref_clk) sw_reg == 4'h6);
    c_retry: cover property (@(posedge i_ref_clk) oc_off_reg == OFF_MAX && (|trip));

endmodule : hbdt_ctrl

// >>> pkg/hbdt_pkg.sv
// constants for the bridge protection and dead-time sequencer
package hbdt_pkg;
    localparam int unsigned CLK_HZ         = 40000000;               // reference clock rate
    localparam int unsigned DEAD_NS        = 3000;                   // dead time, ns
    localparam int unsigned OC_FILT_NS     = 10000;                  // overcurrent filter, ns
    localparam int unsigned OC_OFF_US      = 5000;                   // overcurrent off interval, us
    localparam int unsigned HOLD_NS        = 125000;                 // standby hold-over, ns
    // cycle counts: least times round up, filter also up (must exceed)
    localparam int unsigned DEAD_CYC       = (DEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned OC_FILT_CYC    = (OC_FILT_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned OC_OFF_CYC     = OC_OFF_US * (CLK_HZ / 1000000);
    localparam int unsigned HOLD_CYC       = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CNT_W          = 20;                     // width of timers
    // switch vector bit positions {upper_a, lower_a, upper_b, lower_b}
    localparam int unsigned SW_UA          = 3;
    localparam int unsigned SW_LA          = 2;
    localparam int unsigned SW_UB          = 1;
    localparam int unsigned SW_LB          = 0;
    localparam logic [3:0]  SW_OFF         = 4'h0;                   // all switches off
    // bridge mode
    typedef enum logic [1:0] {
        HBDT_STANDBY = 2'b00,
        HBDT_FWD     = 2'b01,
        HBDT_BWD     = 2'b10,
        HBDT_BRAKE   = 2'b11
    } hbdt_mode_t;
endpackage : hbdt_pkg

// >>> sim/hbdt_host_model.sv
// host controller model driving the direction and pwm pins
`timescale 1ns/10ps
module hbdt_host_model (
    input  wire logic                 i_ref_clk,        // bench clock
    input  wire hbdt_pkg::hbdt_mode_t i_mode,           // wanted bridge mode
    input  wire logic                 i_pwm_low,        // pwm off phase on the active pin
    output logic                      o_forward_input,  // to forward pin
    output logic                      o_backward_input  // to backward pin
);
    ////////////////////////////////////////////////////////////////////////
    // levels move on the falling edge only, away from the sampling edge
    always @(negedge i_ref_clk) begin
        o_forward_input  <= i_mode[0] & ~(i_pwm_low & ~i_mode[1]);
        o_backward_input <= i_mode[1] & ~(i_pwm_low & ~i_mode[0]);
    end
endmodule : hbdt_host_model

// >>> sim/tb_hbridge_fault_deadtime_control.sv
// self-checking bench for the bridge protection and dead-time sequencer
`timescale 1ns/10ps
module tb_hbridge_fault_deadtime_control;
    logic                 i_ref_clk = 1'b0;    // 40 MHz clock
    logic                 i_arst_n  = 1'b0;    // reset, active low
    logic                 uv_ok     = 1'b0;    // supply good flag
    logic                 ov        = 1'b0;    // overvoltage flag
    logic                 hot       = 1'b0;    // thermal flag
    logic [3:0]           trip      = 4'h0;    // per-switch current flags
    logic                 pwm_low   = 1'b0;    // pwm off phase request
    hbdt_pkg::hbdt_mode_t mode      = hbdt_pkg::HBDT_STANDBY; // host mode
    wire logic            forward_input;                 // forward pin
    wire logic            bwd;                 // backward pin
    logic                 ua, la, ub, lb;      // gate drives
    logic                 active;              // internal circuits on
    logic                 fault;               // protection active
    int                   err_count    = 0;    // mismatches
    int                   total_checks = 0;    // comparisons
    int                   n;                   // measured cycles
    int                   b;                   // random switch index
    int                   w;                   // random pwm width
    always #12.5 i_ref_clk = ~i_ref_clk;
    ////////////////////////////////////////////////////////////////////////
    hbdt_host_model u_host (.i_ref_clk(i_ref_clk), .i_mode(mode), .i_pwm_low(pwm_low),
                            .o_forward_input(forward_input), .o_backward_input(bwd));
    hbdt_ctrl u_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_forward_input(forward_input),
                     .i_backward_input(bwd), .i_uv_ok(uv_ok), .i_ov_flag(ov),
                     .i_current_limit_trip(trip), .i_thermal_flag(hot), .o_upper_switch_a(ua),
                     .o_lower_switch_a(la), .o_upper_switch_b(ub), .o_lower_switch_b(lb),
                     .o_active(active), .o_fault(fault));
    ////////////////////////////////////////////////////////////////////////
    // expected switch pattern for a mode, pwm off phase drops the lower side
    function automatic logic [3:0] exp_sw(input hbdt_pkg::hbdt_mode_t m, input logic p);
        logic [3:0] s;
        s = hbdt_pkg::SW_OFF;
        if (m == hbdt_pkg::HBDT_FWD) begin
            s[hbdt_pkg::SW_UA] = 1'b1;
            s[hbdt_pkg::SW_LB] = ~p;
        end else if (m == hbdt_pkg::HBDT_BWD) begin
            s[hbdt_pkg::SW_UB] = 1'b1;
            s[hbdt_pkg::SW_LA] = ~p;
        end else if (m == hbdt_pkg::HBDT_BRAKE) begin
            s[hbdt_pkg::SW_LA] = 1'b1;
            s[hbdt_pkg::SW_LB] = 1'b1;
        end
        return s;
    endfunction : exp_sw
    // observed value of one output group
    function automatic logic [3:0] seen(input int k);
        if (k == 0) return {ua, la, ub, lb};
        if (k == 1) return {3'h0, fault};
        return {3'h0, active};
    endfunction : seen
    task automatic cyc(input int c);
        repeat (c) @(negedge i_ref_clk);
    endtask : cyc
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk_sw(input logic [3:0] e);
        total_checks++;
        if (seen(0) !== e) begin
            $display("MISMATCH switches exp %h seen %h", e, seen(0));
            err_count++;
        end
    endtask : chk_sw
    task automatic chk_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            $display("MISMATCH %s exp %b seen %b", nm, e, s);
            err_count++;
        end
    endtask : chk_bit
    task automatic chk_ge(input string nm, input int lo, input int s);
        total_checks++;
        if (s < lo) begin
            $display("MISMATCH %s exp >=%0d seen %0d", nm, lo, s);
            err_count++;
        end
    endtask : chk_ge
    // bounded wait for an output group to reach a value
    task automatic wait_for(input int k, input logic [3:0] e, input int max, output int c);
        c = 0;
        while (seen(k) !== e && c < max) begin
            cyc(1);
            c++;
        end
        total_checks++;
        if (seen(k) !== e) begin
            $display("MISMATCH wait group %0d exp %h seen %h", k, e, seen(k));
            err_count++;
            end_sim();
        end
    endtask : wait_for
    task automatic set_flt(input int k, input logic v);
        if (k == 0) uv_ok = ~v;
        else if (k == 1) ov = v;
        else hot = v;
    endtask : set_flt
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'h751e));
        cyc(10);
        i_arst_n = 1'b1;
        mode = hbdt_pkg::HBDT_FWD;
        cyc(300);
        chk_sw(4'h0);
        chk_bit("active", 1'b0, active);
        uv_ok = 1'b1;
        cyc(100);
        chk_sw(4'h0);
        wait_for(0, exp_sw(hbdt_pkg::HBDT_FWD, 1'b0), 60, n);
        $display("test start done");
        for (int i = 0; i < 4; i++) begin
            w = $urandom_range(20, 60);
            pwm_low = 1'b1;
            cyc(15);
            chk_sw(exp_sw(hbdt_pkg::HBDT_FWD, 1'b1));
            cyc(w - 15);
            pwm_low = 1'b0;
            wait_for(0, exp_sw(hbdt_pkg::HBDT_FWD, 1'b0), 200, n);
        end
        mode = hbdt_pkg::HBDT_BWD;
        cyc(12);
        chk_sw(4'h0);
        cyc(88);
        chk_sw(4'h0);
        wait_for(0, exp_sw(hbdt_pkg::HBDT_BWD, 1'b0), 60, n);
        $display("test pwm and reversal done");
        for (int i = 0; i < 7; i++) begin
            mode = (i == 6) ? hbdt_pkg::HBDT_BRAKE : hbdt_pkg::hbdt_mode_t'($urandom_range(1, 3));
            wait_for(0, exp_sw(mode, 1'b0), 300, n);
        end
        mode = hbdt_pkg::HBDT_STANDBY;
        wait_for(2, 4'h0, 20, n);
        mode = hbdt_pkg::HBDT_FWD;
        wait_for(0, exp_sw(hbdt_pkg::HBDT_FWD, 1'b0), 300, n);
        mode = hbdt_pkg::HBDT_STANDBY;
        cyc(4900);
        chk_bit("active", 1'b1, active);
        chk_sw(exp_sw(hbdt_pkg::HBDT_FWD, 1'b1));
        wait_for(2, 4'h0, 200, n);
        chk_ge("hold", 5000, 4900 + n);
        chk_sw(4'h0);
        $display("test modes done");
        mode = hbdt_pkg::HBDT_FWD;
        wait_for(0, exp_sw(hbdt_pkg::HBDT_FWD, 1'b0), 300, n);
        for (int k = 0; k < 3; k++) begin
            set_flt(k, 1'b1);
            wait_for(0, 4'h0, 10, n);
            cyc(2);
            chk_bit("fault", 1'b1, fault);
            if (k == 0) chk_bit("active", 1'b0, active);
            set_flt(k, 1'b0);
            wait_for(0, exp_sw(hbdt_pkg::HBDT_FWD, 1'b0), 200, n);
        end
        ov = 1'b1;
        hot = 1'b1;
        wait_for(0, 4'h0, 10, n);
        ov = 1'b0;
        cyc(200);
        chk_sw(4'h0);
        chk_bit("fault", 1'b1, fault);
        hot = 1'b0;
        wait_for(0, exp_sw(hbdt_pkg::HBDT_FWD, 1'b0), 200, n);
        $display("test faults done");
        b = $urandom_range(0, 3);
        trip[b] = 1'b1;
        cyc(300);
        trip = 4'h0;
        cyc(30);
        chk_bit("fault", 1'b0, fault);
        chk_sw(exp_sw(hbdt_pkg::HBDT_FWD, 1'b0));
        trip[b] = 1'b1;
        wait_for(1, 4'h1, 450, n);
        chk_ge("filter", 400, n);
        chk_sw(4'h0);
        trip = 4'h0;
        wait_for(1, 4'h0, 200100, n);
        chk_ge("off time", 199500, n);
        wait_for(0, exp_sw(hbdt_pkg::HBDT_FWD, 1'b0), 200, n);
        trip = 4'hf;
        wait_for(1, 4'h1, 450, n);
        cyc(200300);
        chk_bit("fault", 1'b1, fault);
        chk_sw(4'h0);
        trip = 4'h0;
        $display("test overcurrent done");
        end_sim();
    end
endmodule : tb_hbridge_fault_deadtime_control
